// *** verilog/dpr_ram_ctrl.sv ***
// dual-port dram controller with sec-ded ecc, mode control and error log
// Contract
// [R1] memory reachable from both bus ports, each with its own window, 16 MB total
// [R2] system port: board sits in one of four 4 MB pages chosen by jumpers
// [R3] system page holds 256 blocks of 16K; window starts at jumpered base block
// [R4] decoder supports board partitions as small as 8K
// [R5] local port: 256 blocks of 64K, no page, base block by jumpers
// [R6] local port served directly, no arbitration wait, lower latency than system
// [R7] byte and word transfers with 24-bit addresses
// [R8] correct single-bit errors, detect double and most multi-bit errors
// [R9] control and error log share one i/o port address
// [R10] i/o port at one of nine jumpered addresses; spare codes unused
// [R11] six modes via control; either irq policy with either correct setting
// [R12] any-error policy interrupts on single or multiple errors
// [R13] uncorrectable policy interrupts on multiple-bit errors only
// [R14] correcting mode fixes single errors, passes uncorrectable data unchanged
// [R15] non-correcting mode still checks and interrupts, never alters data
// [R16] diagnostic mode never writes check bits
// [R17] examine mode logs syndrome on reads, generated check bits on writes
// [R18] examine mode bypasses the status translation, raw word logged
// [R19] error log is 8 bits: bit7 one, row in 6:5, bit code in 4:0
// [R20] codes: 0-15 data bit, 16-21 check bit, 30 no error, 31 uncorrectable
// [R21] port writes load control, port reads return the error log
// [R22] byte writes read, merge, and rewrite with fresh check bits
`include "dpr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module dpr_ram_ctrl #(
  parameter int BYTES_LOG2 = 17
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // system bus port
  input wire logic SB_VALID_I,
  input wire dpr_pkg::dpr_mreq_t SB_REQ_I,
  output logic SB_ACK_O,
  output logic [15:0] SB_RDATA_O,
  input wire logic [1:0] SB_PAGE_I,
  input wire logic [7:0] SB_BASE_I,
  input wire logic [3:0] IO_SEL_I,
  // local bus port
  input wire logic LB_VALID_I,
  input wire dpr_pkg::dpr_mreq_t LB_REQ_I,
  output logic LB_ACK_O,
  output logic [15:0] LB_RDATA_O,
  input wire logic [7:0] LB_BASE_I,
  // error interrupt to the host
  output logic IRQ_O,
  // axi4-lite slave
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import dpr_pkg::*;

  localparam int AW = BYTES_LOG2 - 1;
  localparam int DEPTH = 1 << AW;
  localparam logic [23:0] BOARD_BYTES = 24'h000001 << BYTES_LOG2;

  ////////////////////////////////////////////////////////////////////////////
  // ecc helpers: hamming over 16 data bits plus overall parity

  // data bit j owns the j-th 5-bit code of weight two or more
  function automatic logic [4:0] code_of(input int j);
    int n;
    logic [4:0] r;
    begin
      n = 0;
      r = 5'h00;
      for (int v = 3; v < 32; v++) begin
        if ((v & (v - 1)) != 0) begin
          if (n == j) begin
            r = v[4:0];
          end
          n++;
        end
      end
      return r;
    end
  endfunction : code_of

  // six check bits; bit5 makes overall parity of all 22 bits even
  function automatic logic [5:0] gen_chk(input logic [15:0] d);
    logic [5:0] c;
    logic [4:0] k;
    begin
      c = 6'h00;
      for (int j = 0; j < 16; j++) begin
        k = code_of(j);
        for (int b = 0; b < 5; b++) begin
          if (k[b]) begin
            c[b] = c[b] ^ d[j];
          end
        end
      end
      c[5] = ^{d, c[4:0]};
      return c;
    end
  endfunction : gen_chk

  ////////////////////////////////////////////////////////////////////////////
  // state and storage

  dpr_regs_t r_q;
  dpr_regs_t r_d;
  logic [21:0] mem_q [0:DEPTH-1];
  logic mem_we;
  logic [21:0] mem_wd;

  logic [23:0] sb_base;
  logic [21:0] sb_off;
  logic [23:0] lb_base;
  logic [23:0] lb_off;
  logic sb_hit;
  logic lb_hit;
  logic io_hit;
  logic [15:0] io_addr;
  logic [21:0] rd_word;
  logic [15:0] rd_data;
  logic [5:0] gen_rd;
  logic [5:0] syn;
  logic [15:0] flip;
  logic err_any;
  logic err_unc;
  logic [4:0] err_code;
  logic [15:0] good;
  logic [15:0] newd;
  logic [5:0] chk_new;
  logic irq_set;
  logic irq_clr;

  ////////////////////////////////////////////////////////////////////////////
  // address windows and i/o decode

  always_comb begin
    sb_base = 24'h000000;
    sb_base[`DPR_SB_BLK_LOG2 +: 8] = SB_BASE_I;
    sb_off = SB_REQ_I.addr[21:0] - sb_base[21:0];
    // system window: page match, then base block within the page
    sb_hit = !SB_REQ_I.io && (SB_REQ_I.addr[23:22] == SB_PAGE_I) // [R2]
      && (SB_REQ_I.addr[21:0] >= sb_base[21:0]) // [R3]
      && ({2'h0, sb_off} < BOARD_BYTES); // [R4]
    lb_base = 24'h000000;
    lb_base[`DPR_LB_BLK_LOG2 +: 8] = LB_BASE_I;
    lb_off = LB_REQ_I.addr - lb_base;
    // local window: flat 64K blocks, no page level
    lb_hit = !LB_REQ_I.io && (LB_REQ_I.addr >= lb_base) // [R5]
      && (lb_off < BOARD_BYTES); // [R1]
    // codes 9..15 are spare and answer nowhere
    io_addr = `DPR_IO_BASE + ({12'h000, IO_SEL_I} * `DPR_IO_STRIDE);
    io_hit = SB_REQ_I.io && (IO_SEL_I < `DPR_IO_NUM) // [R10]
      && (SB_REQ_I.addr[15:0] == io_addr); // [R9]
  end

  ////////////////////////////////////////////////////////////////////////////
  // ecc datapath on the latched word

  always_comb begin
    rd_word = mem_q[r_q.widx[AW-1:0]];
    rd_data = rd_word[15:0];
    gen_rd = gen_chk(rd_data);
    syn = {^rd_word, gen_rd[4:0] ^ rd_word[20:16]};
    flip = 16'h0000;
    err_code = `DPR_CODE_NONE;
    err_any = (syn != 6'h00);
    err_unc = 1'b0;
    // single error flips overall parity; even parity with nonzero is double
    if (err_any) begin
      if (!syn[5]) begin
        err_unc = 1'b1; // [R8]
      end else if (syn[4:0] == 5'h00) begin
        err_code = `DPR_CODE_CHK + 5'h05;
      end else if ((syn[4:0] & (syn[4:0] - 5'h01)) == 5'h00) begin
        err_code = 5'h00;
        for (int b = 0; b < 5; b++) begin
          if (syn[b]) begin
            err_code = `DPR_CODE_CHK + 5'(b);
          end
        end
      end else begin
        err_unc = 1'b1;
        for (int j = 0; j < 16; j++) begin
          if (syn[4:0] == code_of(j)) begin
            err_unc = 1'b0;
            err_code = 5'(j);
            flip = 16'h0001 << j;
          end
        end
      end
      if (err_unc) begin
        err_code = `DPR_CODE_UNC; // [R20]
      end
    end
    // uncorrectable words keep flip at zero and pass unchanged
    good = r_q.ctrl.correct_en ? (rd_data ^ flip) : rd_data; // [R14] [R15]
    // byte lanes merge into the checked word before rewrite
    newd = good;
    if (r_q.req.be[0]) begin
      newd[7:0] = r_q.req.wdata[7:0]; // [R22]
    end
    if (r_q.req.be[1]) begin
      newd[15:8] = r_q.req.wdata[15:8]; // [R7]
    end
    chk_new = gen_chk(newd);
    // diagnostic mode holds the stored check bits
    mem_wd = {r_q.ctrl.diag ? rd_word[21:16] : chk_new, newd}; // [R16]
    mem_we = (r_q.st == ST_ACC) && r_q.req.we;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    r_d = r_q;
    irq_set = 1'b0;
    irq_clr = 1'b0;
    // access sequencer
    case (r_q.st)
      ST_IDLE: begin
        // local port wins a tie and skips the system bus wait
        if (LB_VALID_I && lb_hit) begin
          r_d.lb_sel = 1'b1; // [R6]
          r_d.req = LB_REQ_I;
          r_d.widx = lb_off[23:1];
          r_d.cnt = `DPR_LB_WAIT;
          r_d.st = ST_WAIT;
        end else if (SB_VALID_I && sb_hit) begin
          r_d.lb_sel = 1'b0;
          r_d.req = SB_REQ_I;
          r_d.widx = {2'h0, sb_off[21:1]};
          r_d.cnt = `DPR_SB_WAIT;
          r_d.st = ST_WAIT;
        end else if (SB_VALID_I && io_hit) begin
          r_d.lb_sel = 1'b0;
          r_d.req = SB_REQ_I;
          r_d.st = ST_DONE;
          if (SB_REQ_I.we) begin
            r_d.ctrl = dpr_ctrl_t'(SB_REQ_I.wdata[`DPR_CTRL_W-1:0]); // [R21] [R11]
          end else begin
            r_d.rdata = {8'h00, r_q.elog}; // [R21]
            irq_clr = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        r_d.cnt = r_q.cnt - 3'h1;
        if (r_q.cnt == 3'h1) begin
          r_d.st = ST_ACC;
        end
      end
      ST_ACC: begin
        r_d.rdata = good;
        r_d.st = ST_DONE;
        // a full-word write reads nothing, so it checks nothing
        if (r_q.ctrl.examine) begin
          if (r_q.req.we) begin
            r_d.elog = {1'b1, 1'b0, chk_new}; // [R17] [R18]
          end else begin
            r_d.elog = {1'b1, 1'b0, syn}; // [R17] [R18]
          end
        end else if (err_any && (!r_q.req.we || r_q.req.be != 2'h3)) begin
          r_d.elog = {1'b1, r_q.widx[AW-1 -: 2], err_code}; // [R19]
        end
        if (err_any && (!r_q.req.we || r_q.req.be != 2'h3)) begin
          irq_set = !r_q.ctrl.irq_unc_only || err_unc; // [R12] [R13]
        end
      end
      ST_DONE: begin
        r_d.st = ST_IDLE;
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase

    // axi write: address and data taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      r_d.aw_have = 1'b1;
      r_d.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      r_d.w_have = 1'b1;
      r_d.wdata = S_AXI_WDATA;
      r_d.wstrb = S_AXI_WSTRB;
    end
    if (r_q.aw_have && r_q.w_have) begin
      r_d.aw_have = 1'b0;
      r_d.w_have = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = `DPR_RESP_SLVERR;
      if (r_q.awaddr == `DPR_OFF_PORT) begin
        r_d.bresp = `DPR_RESP_OKAY;
        // an axi write in the same cycle as a system bus port write wins
        if (r_q.wstrb[0]) begin
          r_d.ctrl = dpr_ctrl_t'(r_q.wdata[`DPR_CTRL_W-1:0]); // [R21]
        end
      end else if (r_q.awaddr == `DPR_OFF_CTRL_RB) begin
        r_d.bresp = `DPR_RESP_OKAY;
      end
    end
    if (r_q.bvalid && S_AXI_BREADY) begin
      r_d.bvalid = 1'b0;
    end

    // axi read: port offset returns the log and releases the interrupt
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      r_d.rvalid = 1'b1;
      r_d.rresp = `DPR_RESP_OKAY;
      r_d.axrdata = 32'h00000000;
      if (S_AXI_ARADDR == `DPR_OFF_PORT) begin
        r_d.axrdata[7:0] = r_q.elog; // [R9]
        irq_clr = 1'b1;
      end else if (S_AXI_ARADDR == `DPR_OFF_CTRL_RB) begin
        r_d.axrdata[`DPR_CTRL_W-1:0] = r_q.ctrl;
      end else begin
        r_d.rresp = `DPR_RESP_SLVERR;
      end
    end
    if (r_q.rvalid && S_AXI_RREADY) begin
      r_d.rvalid = 1'b0;
    end

    // an error in the clearing cycle keeps the request up
    if (irq_clr) begin
      r_d.irq = 1'b0;
    end
    if (irq_set) begin
      r_d.irq = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      r_q <= '0;
      r_q.st <= ST_IDLE;
      r_q.ctrl <= `DPR_CTRL_RST;
      r_q.elog <= `DPR_ELOG_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // array has no reset; contents are undefined until written
  always_ff @(posedge CLK_I) begin
    if (mem_we) begin
      mem_q[r_q.widx[AW-1:0]] <= mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign SB_ACK_O = (r_q.st == ST_DONE) && !r_q.lb_sel;
  assign LB_ACK_O = (r_q.st == ST_DONE) && r_q.lb_sel;
  assign SB_RDATA_O = r_q.rdata;
  assign LB_RDATA_O = r_q.rdata;
  assign IRQ_O = r_q.irq;
  assign S_AXI_AWREADY = !r_q.aw_have && !r_q.bvalid;
  assign S_AXI_WREADY = !r_q.w_have && !r_q.bvalid;
  assign S_AXI_BVALID = r_q.bvalid;
  assign S_AXI_BRESP = r_q.bresp;
  assign S_AXI_ARREADY = !r_q.rvalid;
  assign S_AXI_RVALID = r_q.rvalid;
  assign S_AXI_RDATA = r_q.axrdata;
  assign S_AXI_RRESP = r_q.rresp;

endmodule : dpr_ram_ctrl

`default_nettype wire

// *** verilog/dpr_cfg.svh ***
// constants for the dual-port ecc ram controller
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH

// axi4-lite register offsets (byte addresses)
`define DPR_AXI_AW 4
`define DPR_OFF_PORT 4'h0
`define DPR_OFF_CTRL_RB 4'h4
`define DPR_RESP_OKAY 2'h0
`define DPR_RESP_SLVERR 2'h2

// control register: bit0 irq policy, bit1 correct, bit2 diag, bit3 examine
`define DPR_CTRL_W 4
`define DPR_CTRL_RST 4'h2

// error log field values
`define DPR_ELOG_RST 8'hDE
`define DPR_CODE_CHK 5'h10
`define DPR_CODE_NONE 5'h1E
`define DPR_CODE_UNC 5'h1F

// address map geometry
`define DPR_PAGE_LOG2 22
`define DPR_SB_BLK_LOG2 14
`define DPR_LB_BLK_LOG2 16
`define DPR_MIN_PART_LOG2 13

// i/o port decode: nine jumper-selected addresses
`define DPR_IO_BASE 16'h00C0
`define DPR_IO_STRIDE 16'h0002
`define DPR_IO_NUM 4'h9

// wait counts before the array cycle, in clocks
`define DPR_SB_WAIT 3'h3
`define DPR_LB_WAIT 3'h1

`endif

// *** verilog/dpr_pkg.sv ***
// types for the dual-port ecc ram controller
package dpr_pkg;

  // one memory or i/o request from a bus port
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic we;
    logic io;
  } dpr_mreq_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WAIT = 5'h02,
    ST_ACC = 5'h04,
    ST_DONE = 5'h08,
    ST_SPARE = 5'h10
  } dpr_state_t;

  typedef struct packed {
    logic examine;
    logic diag;
    logic correct_en;
    logic irq_unc_only;
  } dpr_ctrl_t;

  typedef struct packed {
    logic one;
    logic [1:0] row;
    logic [4:0] code;
  } dpr_elog_t;

  typedef struct packed {
    dpr_state_t st;
    logic lb_sel;
    dpr_mreq_t req;
    logic [22:0] widx;
    logic [2:0] cnt;
    dpr_ctrl_t ctrl;
    dpr_elog_t elog;
    logic irq;
    logic [15:0] rdata;
    logic aw_have;
    logic [3:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] axrdata;
    logic [1:0] rresp;
  } dpr_regs_t;

endpackage : dpr_pkg

// *** test/dpr_ram_ctrl_props.sv ***
// port assertions for the dual-port ecc ram controller
`include "dpr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module dpr_ram_ctrl_props (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic SB_VALID_I,
  input wire dpr_pkg::dpr_mreq_t SB_REQ_I,
  input wire logic SB_ACK_O,
  input wire logic [15:0] SB_RDATA_O,
  input wire logic LB_VALID_I,
  input wire logic LB_ACK_O,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID
);
  import dpr_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////////////////////////
  // register read return and i/o answer
  sequence s_rd_ret(logic [3:0] a);
    $rose(S_AXI_RVALID) && $past(S_AXI_ARADDR) == a;
  endsequence
  sequence s_io_ack;
    SB_ACK_O && SB_REQ_I.io;
  endsequence
  ////////////////////////////////////////////////////////////
  // latency from a fresh request; local port is the short one
  AST_SB_LAT: assert property (SB_ACK_O && !SB_REQ_I.io |->
    $past(SB_VALID_I, 5) && !$past(SB_VALID_I, 6)) else $error("system answer not at 5");
  AST_LB_LAT: assert property (LB_ACK_O |->
    $past(LB_VALID_I, 3) && !$past(LB_VALID_I, 4)) else $error("local answer not at 3");
  AST_IO_LAT: assert property (s_io_ack |->
    $past(SB_VALID_I) && !$past(SB_VALID_I, 2)) else $error("i/o answer late");
  AST_ACK_PULSE: assert property (SB_ACK_O || LB_ACK_O |=>
    !SB_ACK_O && !LB_ACK_O) else $error("answer longer than a cycle");
  // error log shape on both read paths, control readback and unmapped reads
  AST_IO_LOG: assert property (s_io_ack and !SB_REQ_I.we |-> SB_RDATA_O[7])
    else $error("i/o log bit7 low");
  AST_RD_LOG: assert property (s_rd_ret(4'h0) |->
    S_AXI_RDATA[7] && S_AXI_RDATA[31:8] == 24'h0) else $error("log read malformed");
  AST_RD_CTRL: assert property (s_rd_ret(4'h4) |->
    S_AXI_RDATA[31:4] == 28'h0 && S_AXI_RRESP == `DPR_RESP_OKAY) else $error("ctrl read bad");
  AST_RD_BAD: assert property ($rose(S_AXI_RVALID) &&
    !($past(S_AXI_ARADDR) inside {4'h0, 4'h4}) |-> S_AXI_RRESP == `DPR_RESP_SLVERR &&
    S_AXI_RDATA == 32'h0) else $error("unmapped read not refused");
endmodule : dpr_ram_ctrl_props
bind dpr_ram_ctrl dpr_ram_ctrl_props u_props (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .SB_VALID_I(SB_VALID_I), .SB_REQ_I(SB_REQ_I), .SB_ACK_O(SB_ACK_O),
  .SB_RDATA_O(SB_RDATA_O), .LB_VALID_I(LB_VALID_I), .LB_ACK_O(LB_ACK_O),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID));
`default_nettype wire

// *** test/dpr_host_bfm.sv ***
// processor-side master for the system and local memory ports
`timescale 1ns/10ps
`default_nettype none
module dpr_host_bfm (
  input wire logic clk_i,
  output logic sb_valid_o,
  output dpr_pkg::dpr_mreq_t sb_req_o,
  input wire logic sb_ack_i,
  input wire logic [15:0] sb_rdata_i,
  output logic lb_valid_o,
  output dpr_pkg::dpr_mreq_t lb_req_o,
  input wire logic lb_ack_i,
  input wire logic [15:0] lb_rdata_i
);
  import dpr_pkg::*;
  dpr_mreq_t req_q = '0;
  initial begin
    sb_valid_o = 1'b0;
    lb_valid_o = 1'b0;
  end
  // an idle bus shows the inverse of the last request, never a stale copy
  assign sb_req_o = sb_valid_o ? req_q : ~req_q;
  assign lb_req_o = lb_valid_o ? req_q : ~req_q;
  // one transfer, held until the answer edge or until lim cycles pass
  task automatic xfer(input logic lb, input logic [23:0] a, input logic [15:0] d,
      input logic [1:0] be, input logic we, input logic io, input int lim,
      output logic [15:0] rd, output logic got);
    int n;
    n = 0;
    got = 1'b0;
    @(posedge clk_i);
    req_q <= '{addr: a, wdata: d, be: be, we: we, io: io};
    if (lb) lb_valid_o <= 1'b1;
    else sb_valid_o <= 1'b1;
    while (!got && n < lim) begin
      @(posedge clk_i);
      n++;
      got = lb ? lb_ack_i : sb_ack_i;
    end
    rd = lb ? lb_rdata_i : sb_rdata_i;
    sb_valid_o <= 1'b0;
    lb_valid_o <= 1'b0;
  endtask : xfer
endmodule : dpr_host_bfm
`default_nettype wire

// *** test/dual_port_ecc_ram_control_tb_top.sv ***
// self-checking bench for the dual-port ecc ram controller
`include "dpr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module dual_port_ecc_ram_control_tb_top;
  import dpr_pkg::*;
  // jumpered windows; moved once near the end of the run
  logic [23:0] sb_win = 24'h414000;
  logic [23:0] lb_win = 24'h210000;
  logic [1:0] sb_pg = 2'h1;
  logic [7:0] sb_bs = 8'h05;
  logic [7:0] lb_bs = 8'h21;
  localparam logic [23:0] IO_ADR = 24'h0000C6;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] io_sel = 4'h3;
  logic [3:0] ctrl = 4'h2;
  logic sb_v, lb_v, sb_ack, lb_ack, irq, awr, wr_r, bv, arr, rv;
  logic [15:0] sb_rd, lb_rd;
  dpr_mreq_t sb_rq, lb_rq;
  logic [3:0] awa = 4'h0;
  logic [3:0] ara = 4'h0;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdat;
  int mm[int];
  int mc[int];
  int err_total = 0;
  int check_count = 0;
  integer seed = 32'he9ff;
  logic [24:0] bad [3] = '{{1'b0, 24'h814000}, {1'b0, 24'h410000}, {1'b1, 24'h212000}};
  ////////////////////////////////////////////////////////////
  // design on an 8K board so windows stay small
  dpr_ram_ctrl #(.BYTES_LOG2(13)) u_dut (.CLK_I(clk), .RST_N_I(rst_n), .SB_VALID_I(sb_v),
    .SB_REQ_I(sb_rq), .SB_ACK_O(sb_ack), .SB_RDATA_O(sb_rd), .SB_PAGE_I(sb_pg),
    .SB_BASE_I(sb_bs), .IO_SEL_I(io_sel), .LB_VALID_I(lb_v), .LB_REQ_I(lb_rq),
    .LB_ACK_O(lb_ack), .LB_RDATA_O(lb_rd), .LB_BASE_I(lb_bs), .IRQ_O(irq),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre));
  dpr_host_bfm u_host (.clk_i(clk), .sb_valid_o(sb_v), .sb_req_o(sb_rq), .sb_ack_i(sb_ack),
    .sb_rdata_i(sb_rd), .lb_valid_o(lb_v), .lb_req_o(lb_rq), .lb_ack_i(lb_ack),
    .lb_rdata_i(lb_rd));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  // register bus master; each channel released once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awr && awv) awv <= 1'b0;
      if (wr_r && wv) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = bresp;
    bre <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arr && arv) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdat;
    r = rresp;
    rre <= 1'b0;
  endtask : axi_rd
  // control through either path, then read it back
  task automatic set_ctrl(input logic [3:0] c, input logic io);
    logic [15:0] rd;
    logic [31:0] x;
    logic [1:0] r;
    logic g;
    if (io) u_host.xfer(1'b0, IO_ADR, {12'h0, c}, 2'b11, 1'b1, 1'b1, 20, rd, g);
    else axi_wr(4'h0, {28'h0, c}, r);
    ctrl = c;
    axi_rd(4'h4, x, r);
    check("ctrl", x, {28'h0, c});
  endtask : set_ctrl
  // reading the log also drops the interrupt
  task automatic get_log(input logic io, output logic [7:0] l);
    logic [15:0] rd;
    logic [31:0] x;
    logic [1:0] r;
    logic g;
    if (io) u_host.xfer(1'b0, IO_ADR, 16'h0, 2'b11, 1'b0, 1'b1, 20, rd, g);
    else axi_rd(4'h0, x, r);
    l = io ? rd[7:0] : x[7:0];
    @(posedge clk);
    check("irq clear", irq, 1'b0);
  endtask : get_log
  // memory write; diagnostic mode leaves the check-bit copy alone
  task automatic wr(input logic lb, input int off, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] rd, nv;
    logic g;
    nv = mm.exists(off / 2) ? 16'(mm[off / 2]) : 16'h0;
    u_host.xfer(lb, (lb ? lb_win : sb_win) + 24'(off), d, be, 1'b1, 1'b0, 40, rd, g);
    check("wr ack", g, 1'b1);
    if (be[0]) nv[7:0] = d[7:0];
    if (be[1]) nv[15:8] = d[15:8];
    mm[off / 2] = nv;
    if (!ctrl[2]) mc[off / 2] = nv;
  endtask : wr
  // memory read against the model: flipped bits since the check copy
  task automatic rd_chk(input logic lb, input int off);
    logic [15:0] rd;
    logic g;
    int e;
    e = $countones(mm[off / 2] ^ mc[off / 2]);
    u_host.xfer(lb, (lb ? lb_win : sb_win) + 24'(off), 16'h0, 2'b11, 1'b0, 1'b0, 40, rd, g);
    check("rdata", rd, (ctrl[1] && e == 1) ? mc[off / 2] : mm[off / 2]);
    repeat (2) @(posedge clk);
    check("irq", irq, e > 1 || (e == 1 && !ctrl[0]));
  endtask : rd_chk
  ////////////////////////////////////////////////////////////
  // hang guard, far above the several hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end
  // main sequence
  initial begin
    logic [15:0] rd, d, flip;
    logic [31:0] x;
    logic [1:0] r;
    logic [7:0] l;
    logic g;
    int off, j;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check("irq rst", irq, 1'b0);
    axi_rd(4'h4, x, r);
    check("ctrl rst", x, 32'h2);
    get_log(1'b0, l);
    check("log rst", l, 8'hDE);
    // word on one port read on the other, then byte merges
    for (int i = 0; i < 6; i++) begin
      if (i < 4) off = $random(seed) & 32'h1FFE;
      wr(i[0], off, 16'($random(seed)), (i < 4) ? 2'b11 : 2'(1 << (i - 4)));
      rd_chk(!i[0], off);
    end
    // injected errors in every policy and correction setting
    for (int m = 0; m < 8; m++) begin
      set_ctrl({2'b00, m[1], m[0]}, m[0]);
      off = $random(seed) & 32'h1FFE;
      d = 16'($random(seed));
      j = $random(seed) & 15;
      flip = (16'h1 << j) | (m[2] ? 16'h1 << ((j + 5) % 16) : 16'h0);
      wr(1'b0, off, d, 2'b11);
      set_ctrl({2'b01, m[1], m[0]}, 1'b0);
      wr(1'b1, off, d ^ flip, 2'b11);
      set_ctrl({2'b00, m[1], m[0]}, m[0]);
      rd_chk(m[0], off);
      get_log(!m[0], l);
      check("log", l & 8'h9F, m[2] ? 8'h9F : {3'h4, j[4:0]});
    end
    // raw syndrome of a clean word
    set_ctrl(4'h2, 1'b0);
    wr(1'b0, off, 16'($random(seed)), 2'b11);
    set_ctrl(4'hA, 1'b1);
    rd_chk(1'b1, off);
    get_log(1'b0, l);
    check("raw log", l, 8'h80);
    // a write logs its own check bits: data bit 0 feeds c0, c1 and c5
    wr(1'b0, off, 16'h0001, 2'b11);
    get_log(1'b0, l);
    check("raw wr log", l, 8'hA3);
    set_ctrl(4'h2, 1'b0);
    // unmapped and read-only register offsets
    axi_rd(4'h8, x, r);
    check("bad rd", {r, x[29:0]}, {`DPR_RESP_SLVERR, 30'h0});
    axi_wr(4'h8, 32'hF, r);
    check("bad wr", r, `DPR_RESP_SLVERR);
    axi_wr(4'h4, 32'hF, r);
    check("ro wr", r, `DPR_RESP_OKAY);
    axi_rd(4'h4, x, r);
    check("ctrl kept", x, 32'h2);
    // nine i/o addresses answer, spare code 9 does not
    for (int s = 0; s < 10; s++) begin
      @(posedge clk);
      io_sel <= 4'(s);
      u_host.xfer(1'b0, 24'hC0 + 24'(2 * s), 16'h0, 2'b11, 1'b0, 1'b1, 20, rd, g);
      check("io answer", g, s < 9);
    end
    @(posedge clk);
    io_sel <= 4'h3;
    // other page, below base, past the board end
    for (int k = 0; k < 3; k++) begin
      u_host.xfer(bad[k][24], bad[k][23:0], 16'h0, 2'b11, 1'b0, 1'b0, 20, rd, g);
      check("no answer", g, 1'b0);
    end
    // jumpers moved to the top page and the last base blocks on both ports
    @(posedge clk);
    sb_pg <= 2'h3;
    sb_bs <= 8'hFF;
    lb_bs <= 8'hFF;
    sb_win = 24'hFFC000;
    lb_win = 24'hFF0000;
    wr(1'b0, 2, 16'h5A3C, 2'b11);
    rd_chk(1'b1, 2);
    end_sim();
  end
endmodule : dual_port_ecc_ram_control_tb_top
`default_nettype wire
